// ===== src/cipc_top.sv
// wide-io indication, drive select and power control register bank
// Operation
// - address select applies only while internal generation bit is set
// - set bit n drives indication low when host address nibble equals 2n
// - source field: 00 internal, 10 host narrow flag and 11 held high in host io mode, else internal
// - translation field: 00 off, 10 narrow flag, 11 forced, 01 undefined
// - host narrow flag is bit 5 of card config-status register
// - dual-drive bit 0 enables master/slave drive select
// - with bit 0 set, drive ata bus only when written drive bit matches polarity bit
// - drive/head writes are checked at primary and secondary addresses
// - idle timer restarts on host access and expiry powers down signals
// - timeout is clock period times two to 27 times count
// - power bit 0 selects 8-bit local bus, clear 16-bit
// - power bit 1 enables alternate modem pins
// - power bit 2 gates internal clocks after eeprom load
// - power bit 3 powers down host pads unless a card enable active
// - pad power-down blocks host config register access
// - power bit 4 enables timer, clear holds it reset
// - power bit 5 asserts busy while host power-down bit set and power bit 3 clear
// - power bit 6 lets expiry drive external power-down output
// - power bit 7 makes external power-down active low
// - bus bit 1 picks internal indication, else drive's input
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
`include "cipc_params.svh"
module cipc_top import cipc_pkg::*; #(
    parameter int PRESCALE_LOG2 = `CIPC_PRESCALE_LOG2
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    input  wire logic [9:0]  host_address_i,
    input  wire logic        host_io_write_i,
    input  wire logic [7:0]  host_data_i,
    input  wire logic        host_card_enable_low_n_i,
    input  wire logic        host_card_enable_high_n_i,
    input  wire logic        host_io_mode_i,
    input  wire logic [7:0]  card_config_status_reg_i,
    input  wire logic        eeprom_load_done_i,
    input  wire logic        drive_wide_io_n_i,
    output logic             wide_io_n_o,
    output logic             narrow_host_wide_drive_o,
    output logic             drive_bus_enable_o,
    output logic             local_narrow_bus_o,
    output logic             alt_modem_pins_o,
    output logic             clocks_gated_o,
    output logic             host_pads_down_o,
    output logic             config_access_block_o,
    output logic             host_busy_o,
    output logic             noncritical_power_down_o,
    output logic             ext_power_down_out_o
);
    // pin inputs: three stages, a change counts when stages two and three agree
    logic [2:0]  ce1_s_q;
    logic [2:0]  ce2_s_q;
    logic [2:0]  wr_s_q;
    logic [2:0]  iom_s_q;
    logic [2:0]  dio_s_q;
    logic [2:0]  eld_s_q;
    logic        ce1_n_q;
    logic        ce2_n_q;
    logic        wr_q;
    logic        wr_prev_q;
    logic        iom_q;
    logic        dio_n_q;
    logic        eld_q;

    // address and data are sampled every enabled cycle through one stage, with no own synchroniser
    logic [9:0]  adr_q;
    logic [7:0]  dat_q;
    logic [7:0]  csr_q;

    function automatic logic settle(input logic cur, input logic [2:0] s);
        settle = (s[2] == s[1]) ? s[1] : cur;
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ce1_s_q <= 3'h7;
            ce2_s_q <= 3'h7;
            wr_s_q  <= 3'h0;
            iom_s_q <= 3'h0;
            dio_s_q <= 3'h7;
            eld_s_q <= 3'h0;
            ce1_n_q <= 1'b1;
            ce2_n_q <= 1'b1;
            wr_q    <= 1'b0;
            wr_prev_q <= 1'b0;
            iom_q   <= 1'b0;
            dio_n_q <= 1'b1;
            eld_q   <= 1'b0;
        end else if (ce_i) begin
            ce1_s_q <= {ce1_s_q[1:0], host_card_enable_low_n_i};
            ce2_s_q <= {ce2_s_q[1:0], host_card_enable_high_n_i};
            wr_s_q  <= {wr_s_q[1:0], host_io_write_i};
            iom_s_q <= {iom_s_q[1:0], host_io_mode_i};
            dio_s_q <= {dio_s_q[1:0], drive_wide_io_n_i};
            eld_s_q <= {eld_s_q[1:0], eeprom_load_done_i};
            ce1_n_q <= settle(ce1_n_q, ce1_s_q);
            ce2_n_q <= settle(ce2_n_q, ce2_s_q);
            wr_q    <= settle(wr_q, wr_s_q);
            wr_prev_q <= wr_q;
            iom_q   <= settle(iom_q, iom_s_q);
            dio_n_q <= settle(dio_n_q, dio_s_q);
            eld_q   <= settle(eld_q, eld_s_q);
        end
    end

    // one-stage samples of the wide host buses
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            adr_q   <= 10'h000;
            dat_q   <= `CIPC_RST_BYTE;
            csr_q   <= `CIPC_RST_BYTE;
        end else if (ce_i) begin
            adr_q   <= host_address_i;
            dat_q   <= host_data_i;
            csr_q   <= card_config_status_reg_i;
        end
    end

    // registers
    logic [7:0]  bus_ctrl_q;
    logic [7:0]  wide_sel_q;
    logic [7:0]  dual_q;
    logic [7:0]  tcount_q;
    logic [7:0]  pwr_q;
    logic        drv_bit_q;

    wire         wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire         lane0    = wb_sel_i[0];
    wire         hit_bus  = (wb_adr_i == `CIPC_OFS_BUS_CTRL);
    wire         hit_sel  = (wb_adr_i == `CIPC_OFS_WIDE_IO_SEL);
    wire         hit_dual = (wb_adr_i == `CIPC_OFS_DUAL_DRIVE);
    wire         hit_tcnt = (wb_adr_i == `CIPC_OFS_TIMER_COUNT);
    wire         hit_pwr  = (wb_adr_i == `CIPC_OFS_POWER_CTRL);
    wire         hit_stat = (wb_adr_i == `CIPC_OFS_STATUS);
    wire         hit_any  = hit_bus | hit_sel | hit_dual | hit_tcnt | hit_pwr | hit_stat;
    // a write lands at the ack edge, while address and data still stand
    wire         wr_en    = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && lane0 && hit_any;
    wire         wr_bus   = wr_en && hit_bus;
    wire         wr_sel   = wr_en && hit_sel;
    wire         wr_dual  = wr_en && hit_dual;
    wire         wr_tcnt  = wr_en && hit_tcnt;
    wire         wr_pwr   = wr_en && hit_pwr;

    // host side decode
    wire         card_sel   = !ce1_n_q || !ce2_n_q;
    wire         pads_off   = pwr_q[`CIPC_PC_PADS_BIT];
    wire         host_wr_edge = wr_q && !wr_prev_q;
    wire         host_access = card_sel && host_wr_edge;
    wire         drvhead_hit = (adr_q == `CIPC_DRVHEAD_PRI) || (adr_q == `CIPC_DRVHEAD_SEC);
    wire         narrow_flag = csr_q[`CIPC_CSR_NARROW_BIT];
    wire         pwrdn_req   = csr_q[`CIPC_CSR_PWRDN_BIT] && !pads_off;
    wire         nib_even    = !adr_q[0];
    wire         nib_hit     = nib_even && wide_sel_q[adr_q[3:1]];
    wire         int_gen     = bus_ctrl_q[`CIPC_BUS_INT_GEN_BIT];
    cipc_sel_t   src_sel;
    cipc_sel_t   ntw_sel;
    assign src_sel = cipc_sel_t'(bus_ctrl_q[`CIPC_BUS_SRC_LSB +: 2]);
    assign ntw_sel = cipc_sel_t'(bus_ctrl_q[`CIPC_BUS_NTW_LSB +: 2]);

    logic        wide_n_d;
    logic        ntw_d;
    always_comb begin
        wide_n_d = dio_n_q;
        if (int_gen) begin
            unique case (src_sel)
                CIPC_SRC_INTERNAL: wide_n_d = !(card_sel && nib_hit);
                CIPC_SRC_NARROW:   wide_n_d = iom_q ? narrow_flag : !(card_sel && nib_hit);
                CIPC_SRC_HIGH:     wide_n_d = iom_q ? 1'b1 : !(card_sel && nib_hit);
                CIPC_SRC_UNDEF:    wide_n_d = !(card_sel && nib_hit);
            endcase
        end
        unique case (ntw_sel)
            CIPC_SRC_INTERNAL: ntw_d = 1'b0;
            CIPC_SRC_NARROW:   ntw_d = narrow_flag;
            CIPC_SRC_HIGH:     ntw_d = 1'b1;
            CIPC_SRC_UNDEF:    ntw_d = 1'b0;
        endcase
    end

    // idle timer
    cipc_timer_if tif ();
    assign tif.enable  = pwr_q[`CIPC_PC_TIMER_EN_BIT];
    assign tif.restart = card_sel && (wr_q || host_wr_edge);
    assign tif.count   = tcount_q;

    cipc_idle_timer #(
        .PRESCALE_LOG2 (PRESCALE_LOG2)
    ) u_timer (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .tif   (tif)
    );

    wire         ext_active = pwr_q[`CIPC_PC_EXT_PD_EN_BIT] && tif.expired;
    wire         ext_level  = pwr_q[`CIPC_PC_EXT_PD_POL_BIT] ? !ext_active : ext_active;

    wire [7:0]   status = {2'b00, tif.expired, drv_bit_q, eld_q, card_sel, host_busy_o, ext_active};
    logic [7:0]  rd_byte;
    always_comb begin
        rd_byte = `CIPC_RST_BYTE;
        if (hit_bus)  rd_byte = bus_ctrl_q;
        if (hit_sel)  rd_byte = wide_sel_q;
        if (hit_dual) rd_byte = dual_q & `CIPC_DD_MASK;
        if (hit_tcnt) rd_byte = tcount_q;
        if (hit_pwr)  rd_byte = pwr_q;
        if (hit_stat) rd_byte = status;
    end

    // wishbone slave: one-cycle answer, unmapped offsets answer with err
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= wb_req && hit_any;
            wb_err_o <= wb_req && !hit_any;
            wb_dat_o <= {24'h00_0000, rd_byte};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_ctrl_q <= `CIPC_RST_BYTE;
            wide_sel_q <= `CIPC_RST_BYTE;
            dual_q     <= `CIPC_RST_BYTE;
            tcount_q   <= `CIPC_RST_BYTE;
            pwr_q      <= `CIPC_RST_BYTE;
        end else if (ce_i) begin
            if (wr_bus)  bus_ctrl_q <= wb_dat_i[7:0];
            if (wr_sel)  wide_sel_q <= wb_dat_i[7:0];
            if (wr_dual) dual_q     <= wb_dat_i[7:0] & `CIPC_DD_MASK;
            if (wr_tcnt) tcount_q   <= wb_dat_i[7:0];
            if (wr_pwr)  pwr_q      <= wb_dat_i[7:0];
        end
    end

    // drive select latch from host drive/head writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drv_bit_q <= 1'b0;
        end else if (ce_i && host_access && drvhead_hit) begin
            drv_bit_q <= dat_q[`CIPC_DRVHEAD_DRV_BIT];
        end
    end

    wire         ms_en     = dual_q[`CIPC_DD_ENABLE_BIT];
    wire         drive_ok  = !ms_en || (drv_bit_q == dual_q[`CIPC_DD_POL_BIT]);

    // registered outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wide_io_n_o              <= 1'b1;
            narrow_host_wide_drive_o <= 1'b0;
            drive_bus_enable_o       <= 1'b1;
        end else if (ce_i) begin
            wide_io_n_o              <= wide_n_d;
            narrow_host_wide_drive_o <= ntw_d;
            drive_bus_enable_o       <= drive_ok;
        end
    end

    // local interface options
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            local_narrow_bus_o       <= 1'b0;
            alt_modem_pins_o         <= 1'b0;
            clocks_gated_o           <= 1'b0;
        end else if (ce_i) begin
            local_narrow_bus_o       <= pwr_q[`CIPC_PC_NARROW_BIT];
            alt_modem_pins_o         <= pwr_q[`CIPC_PC_MODEM_BIT];
            clocks_gated_o           <= pwr_q[`CIPC_PC_CLK_OFF_BIT] && eld_q;
        end
    end

    // power-down outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            host_pads_down_o         <= 1'b0;
            config_access_block_o    <= 1'b0;
            host_busy_o              <= 1'b0;
            noncritical_power_down_o <= 1'b0;
            ext_power_down_out_o     <= 1'b0;
        end else if (ce_i) begin
            host_pads_down_o         <= pads_off && !card_sel;
            config_access_block_o    <= pads_off;
            host_busy_o              <= pwr_q[`CIPC_PC_BUSY_PD_BIT] && pwrdn_req;
            noncritical_power_down_o <= tif.expired;
            ext_power_down_out_o     <= ext_level;
        end
    end
endmodule

// ===== include/cipc_params.svh
// constants for the card wide-io, drive-select and power control block
`ifndef CIPC_PARAMS_SVH
`define CIPC_PARAMS_SVH
`define CIPC_OFS_BUS_CTRL      8'h26
`define CIPC_OFS_WIDE_IO_SEL   8'h27
`define CIPC_OFS_DUAL_DRIVE    8'h28
`define CIPC_OFS_TIMER_COUNT   8'h2a
`define CIPC_OFS_POWER_CTRL    8'h2b
`define CIPC_OFS_STATUS        8'h30
`define CIPC_RST_BYTE          8'h00
`define CIPC_BUS_INT_GEN_BIT   1
`define CIPC_BUS_NTW_LSB       2
`define CIPC_BUS_SRC_LSB       5
`define CIPC_DD_ENABLE_BIT     0
`define CIPC_DD_POL_BIT        1
`define CIPC_DD_MASK           8'h03
`define CIPC_PC_NARROW_BIT     0
`define CIPC_PC_MODEM_BIT      1
`define CIPC_PC_CLK_OFF_BIT    2
`define CIPC_PC_PADS_BIT       3
`define CIPC_PC_TIMER_EN_BIT   4
`define CIPC_PC_BUSY_PD_BIT    5
`define CIPC_PC_EXT_PD_EN_BIT  6
`define CIPC_PC_EXT_PD_POL_BIT 7
`define CIPC_CSR_NARROW_BIT    5
`define CIPC_CSR_PWRDN_BIT     2
`define CIPC_DRVHEAD_DRV_BIT   4
`define CIPC_DRVHEAD_PRI       10'h1f6
`define CIPC_DRVHEAD_SEC       10'h176
`define CIPC_PRESCALE_LOG2     27
`endif

// ===== include/cipc_pkg.sv
// types shared by the card wide-io and power control block
package cipc_pkg;
    typedef enum logic [1:0] {
        CIPC_SRC_INTERNAL = 2'b00,
        CIPC_SRC_UNDEF    = 2'b01,
        CIPC_SRC_NARROW   = 2'b10,
        CIPC_SRC_HIGH     = 2'b11
    } cipc_sel_t;
    typedef enum logic [2:0] {
        CIPC_TMR_IDLE    = 3'b001,
        CIPC_TMR_COUNT   = 3'b010,
        CIPC_TMR_EXPIRED = 3'b100
    } cipc_tmr_state_t;
endpackage

// ===== include/cipc_timer_if.sv
// control and status carried between the top and the idle timer
`timescale 1ns/1ps
interface cipc_timer_if;
    logic       enable;
    logic       restart;
    logic [7:0] count;
    logic       expired;
    modport ctrl (output enable, output restart, output count, input expired);
    modport tmr  (input enable, input restart, input count, output expired);
endinterface

// ===== src/cipc_idle_timer.sv
// power management idle timer: prescaler times programmed count
`timescale 1ns/1ps
`include "cipc_params.svh"
module cipc_idle_timer import cipc_pkg::*; #(
    parameter int PRESCALE_LOG2 = `CIPC_PRESCALE_LOG2
) (
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    input  wire logic  ce_i,
    cipc_timer_if.tmr  tif
);
    cipc_tmr_state_t        state_q;
    logic [PRESCALE_LOG2-1:0] pre_q;
    logic [7:0]             units_q;
    wire                    pre_wrap = &pre_q;
    wire                    last_unit = (units_q == tif.count - 8'h01);
    wire                    run = tif.enable && (tif.count != 8'h00);

    assign tif.expired = (state_q == CIPC_TMR_EXPIRED);

    always_ff @(posedge clk_i) begin
        if (rst_i || !run) begin
            state_q <= CIPC_TMR_IDLE;
            pre_q   <= '0;
            units_q <= `CIPC_RST_BYTE;
        end else if (ce_i) begin
            if (tif.restart) begin
                state_q <= CIPC_TMR_COUNT;
                pre_q   <= '0;
                units_q <= `CIPC_RST_BYTE;
            end else begin
                unique case (state_q)
                    CIPC_TMR_IDLE: begin
                        state_q <= CIPC_TMR_COUNT;
                    end
                    CIPC_TMR_COUNT: begin
                        pre_q <= pre_q + 1'b1;
                        if (pre_wrap) begin
                            if (last_unit) begin
                                state_q <= CIPC_TMR_EXPIRED;
                            end else begin
                                units_q <= units_q + 8'h01;
                            end
                        end
                    end
                    CIPC_TMR_EXPIRED: begin
                        state_q <= CIPC_TMR_EXPIRED;
                    end
                endcase
            end
        end
    end
endmodule

// ===== testbench/cipc_top_assertions.sv
// bound checker for the wide-io, drive select and power control block
`timescale 1ns/1ps
module cipc_top_assertions #(
    parameter int PRESCALE_LOG2 = 27
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        wide_io_n_o,
    input wire logic        drive_bus_enable_o,
    input wire logic        local_narrow_bus_o,
    input wire logic        alt_modem_pins_o,
    input wire logic        host_pads_down_o,
    input wire logic        config_access_block_o,
    input wire logic        noncritical_power_down_o,
    input wire logic        ext_power_down_out_o
);
    logic [7:0] pc_q;
    wire        take = wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o && !wb_err_o;
    wire        mapped = wb_adr_i inside {8'h26, 8'h27, 8'h28, 8'h2a, 8'h2b, 8'h30};
    wire        pc_wr = wb_cyc_i && wb_stb_i && ce_i && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h2b;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // shadow of the power control byte, taken at the same edge the design takes it
    always_ff @(posedge clk_i) begin
        if (rst_i) pc_q <= 8'h00;
        else if (pc_wr) pc_q <= wb_dat_i[7:0];
    end
    a_ack_next: assert property (take |=> wb_ack_o != wb_err_o) else $error("no single answer");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_err_unmapped: assert property (take && !mapped |=> wb_err_o) else $error("unmapped not refused");
    a_dd_upper_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h28 |-> wb_dat_o[7:2] == 6'h00)
        else $error("dual drive upper bits set");
    a_block_pads: assert property (host_pads_down_o |-> config_access_block_o)
        else $error("config access open while pads down");
    a_pc_bits: assert property ($stable(pc_q) |-> {alt_modem_pins_o, local_narrow_bus_o} == pc_q[1:0])
        else $error("local bus or modem pin mismatch");
    a_timer_off: assert property ((!pc_q[4])[*4] |-> !noncritical_power_down_o)
        else $error("power down with timer disabled");
    a_ext_off: assert property ((!pc_q[6] && $stable(pc_q))[*4] |-> ext_power_down_out_o == pc_q[7])
        else $error("ext power down active while disabled");
    a_reset_vals: assert property (disable iff (1'b0) rst_i && ce_i |=> wide_io_n_o && drive_bus_enable_o
        && !ext_power_down_out_o && !wb_ack_o) else $error("bad reset levels");
endmodule
bind cipc_top cipc_top_assertions #(.PRESCALE_LOG2(PRESCALE_LOG2)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .wide_io_n_o(wide_io_n_o), .drive_bus_enable_o(drive_bus_enable_o), .local_narrow_bus_o(local_narrow_bus_o),
    .alt_modem_pins_o(alt_modem_pins_o), .host_pads_down_o(host_pads_down_o),
    .config_access_block_o(config_access_block_o), .noncritical_power_down_o(noncritical_power_down_o),
    .ext_power_down_out_o(ext_power_down_out_o));

// ===== testbench/cipc_host_model.sv
// host socket and drive model for the card-side pins
`timescale 1ns/1ps
module cipc_host_model (
    input  wire logic clk_i,
    output logic [9:0] addr_o = 10'h000,
    output logic       wr_o = 1'b0,
    output logic [7:0] data_o = 8'h00,
    output logic       ce_lo_n_o = 1'b1,
    output logic       ce_hi_n_o = 1'b1,
    output logic       io_mode_o = 1'b1,
    output logic [7:0] csr_o = 8'h00,
    output logic       drv_wio_n_o = 1'b1
);
    // strobe held four cycles so the three-stage synchroniser surely sees it
    task io_wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        data_o <= d;
        wr_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        wr_o <= 1'b0;
        data_o <= ~d;
        repeat (2) @(posedge clk_i);
    endtask
endmodule

// ===== testbench/tb_top.sv
// testbench: register, wide-io, drive select and power scenarios
`timescale 1ns/1ps
module tb_top;
    logic        clk_i = 0, rst_i = 1, ce_i = 1, wb_cyc = 0, wb_stb = 0, wb_we = 0, eep = 0, er;
    logic [7:0]  wb_adr = 8'h00, rd;
    logic [31:0] wb_dat = 32'h0000_0000, wb_dat_o;
    logic        wb_ack_o, wb_err_o, wio_n, ntw, dbe, lnb, amp, cgt, pdn, blk, bsy, ncp, ext;
    wire  [9:0]  h_adr;
    wire  [7:0]  h_dat, h_csr;
    wire         h_wr, h_ce1, h_ce2, h_iom, h_dw;
    int          error_cnt = 0, n_checks = 0;
    logic [7:0]  bus_t[7] = '{8'h42, 8'h42, 8'h62, 8'h0c, 8'h04, 8'h08, 8'h08};
    logic [7:0]  csr_t[7] = '{8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00};
    logic [1:0]  exp_t[7] = '{2'b10, 2'b00, 2'b10, 2'b11, 2'b10, 2'b11, 2'b10};
    always #50 clk_i = ~clk_i;
    cipc_host_model hm (.clk_i(clk_i), .addr_o(h_adr), .wr_o(h_wr), .data_o(h_dat), .ce_lo_n_o(h_ce1),
        .ce_hi_n_o(h_ce2), .io_mode_o(h_iom), .csr_o(h_csr), .drv_wio_n_o(h_dw));
    cipc_top #(.PRESCALE_LOG2(3)) uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .host_address_i(h_adr),
        .host_io_write_i(h_wr), .host_data_i(h_dat), .host_card_enable_low_n_i(h_ce1),
        .host_card_enable_high_n_i(h_ce2), .host_io_mode_i(h_iom), .card_config_status_reg_i(h_csr),
        .eeprom_load_done_i(eep), .drive_wide_io_n_i(h_dw), .wide_io_n_o(wio_n), .narrow_host_wide_drive_o(ntw),
        .drive_bus_enable_o(dbe), .local_narrow_bus_o(lnb), .alt_modem_pins_o(amp), .clocks_gated_o(cgt),
        .host_pads_down_o(pdn), .config_access_block_o(blk), .host_busy_o(bsy),
        .noncritical_power_down_o(ncp), .ext_power_down_out_o(ext));
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wb(input logic we, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= {24'h00_0000, d};
        @(posedge clk_i);
        while (!(wb_ack_o || wb_err_o)) @(posedge clk_i);
        rd = wb_dat_o[7:0];
        er = wb_err_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task wio_scan(input logic [7:0] s);
        for (int n = 0; n < 16; n++) begin
            @(posedge clk_i);
            hm.addr_o <= {6'h00, n[3:0]};
            wt(6);
            chk(wio_n, !(n[0] == 1'b0 && s[n/2]));
        end
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        wt(20000);
        error_cnt++;
        end_of_test();
    end
    initial begin
        wt(20);
        rst_i <= 1'b0;
        wb(0, 8'h27, 0); chk(rd, 8'h00);
        wb(0, 8'h29, 0); chk(er, 1);
        wb(1, 8'h28, 8'hff); wb(0, 8'h28, 0); chk(rd, 8'h03);
        $display("register test done");
        hm.ce_lo_n_o <= 1'b0;
        wb(1, 8'h26, 8'h02); wb(1, 8'h27, 8'h80); wio_scan(8'h80);
        wb(1, 8'h27, 8'hff); wio_scan(8'hff);
        wb(1, 8'h27, 8'h00); wb(1, 8'h26, 8'h00);
        hm.drv_wio_n_o <= 1'b0; wt(6); chk(wio_n, 0);
        hm.drv_wio_n_o <= 1'b1; wt(6); chk(wio_n, 1);
        for (int i = 0; i < 7; i++) begin
            wb(1, 8'h26, bus_t[i]);
            hm.csr_o <= csr_t[i];
            wt(6);
            chk({wio_n, ntw}, exp_t[i]);
        end
        ce_i <= 1'b0; hm.drv_wio_n_o <= 1'b0; wt(6); chk(wio_n, 1);
        ce_i <= 1'b1; wt(6); chk(wio_n, 0); hm.drv_wio_n_o <= 1'b1;
        hm.io_mode_o <= 1'b0; wb(1, 8'h26, 8'h42); hm.csr_o <= 8'h00; wt(6); chk(wio_n, 1);
        hm.io_mode_o <= 1'b1;
        $display("wide io test done");
        wb(1, 8'h26, 8'h00); wb(1, 8'h28, 8'h01);
        hm.io_wr(10'h1f6, 8'h10); wt(6); chk(dbe, 0);
        hm.io_wr(10'h176, 8'h00); wt(6); chk(dbe, 1);
        hm.io_wr(10'h1f7, 8'h10); wt(6); chk(dbe, 1);
        wb(1, 8'h28, 8'h03); wt(4); chk(dbe, 0);
        hm.io_wr(10'h176, 8'h10); wt(6); chk(dbe, 1);
        hm.io_wr(10'h1f6, 8'h10); wb(1, 8'h28, 8'h00); wt(4); chk(dbe, 1);
        $display("drive select test done");
        wb(1, 8'h2b, 8'h03); wt(4); chk({lnb, amp}, 2'b11);
        wb(1, 8'h2b, 8'h04); wt(6); chk(cgt, 0);
        eep <= 1'b1; wt(6); chk(cgt, 1);
        wb(1, 8'h2b, 8'h08); wt(6); chk({pdn, blk}, 2'b01);
        hm.ce_lo_n_o <= 1'b1; wt(6); chk({pdn, blk}, 2'b11);
        hm.ce_lo_n_o <= 1'b0; wb(1, 8'h2b, 8'h80); wt(6); chk(ext, 1);
        wb(1, 8'h2b, 8'h20); hm.csr_o <= 8'h04; wt(6); chk(bsy, 1);
        hm.csr_o <= 8'h00; wt(6); chk(bsy, 0);
        $display("power control test done");
        wb(1, 8'h2a, 8'h03); wb(1, 8'h2b, 8'h10);
        hm.io_wr(10'h1f0, 8'h00); wt(10); chk(ncp, 0);
        hm.io_wr(10'h1f0, 8'h00); wt(10); chk(ncp, 0);
        wt(14); chk(ncp, 0); wt(6); chk(ncp, 1); chk(ext, 0);
        wb(1, 8'h2b, 8'h50); wt(4); chk(ext, 1);
        wb(1, 8'h2b, 8'h40); wt(4); chk(ncp, 0);
        wb(1, 8'h2a, 8'h00); wb(1, 8'h2b, 8'h50);
        hm.io_wr(10'h1f0, 8'h00); wt(60); chk(ncp, 0);
        $display("timer test done");
        end_of_test();
    end
endmodule
